// ### src/css_edge.sv
// Rising edge to one-cycle pulse converter
`default_nettype none
module css_edge
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic level_in,
   output logic pulse_out
);
   // -----------------------------------------------------------------
   // Delayed copy
   // -----------------------------------------------------------------
   logic level_q; // Last cycle's level

   // Register the level; reset as if already high, so that a level that is
   // high out of reset gives no false pulse on the first edge
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         level_q <= 1'b1;
      end
      else
      begin
         level_q <= level_in;
      end
   end

   // High in the same cycle as a low-to-high change, until the next clock edge
   assign pulse_out = level_in & ~level_q;
endmodule
`default_nettype wire

// ### src/css_pkg.sv
// Constants for the compare sync/trigger source selector
`default_nettype none
package css_pkg;
   // -----------------------------------------------------------------
   // Select field layout and reset value
   // -----------------------------------------------------------------
   localparam int SEL_W = 5;                         // Select field width
   localparam logic [SEL_W-1:0] SEL_RESET = 5'h0c;   // Timer two by default
   // -----------------------------------------------------------------
   // Source codes
   // -----------------------------------------------------------------
   localparam logic [SEL_W-1:0] CODE_SELF = 5'h1f;   // Own secondary match
   localparam logic [SEL_W-1:0] CODE_EXT2 = 5'h1e;   // Second interrupt pin
   localparam logic [SEL_W-1:0] CODE_EXT1 = 5'h1d;   // First interrupt pin
   localparam logic [SEL_W-1:0] CODE_CTU = 5'h1c;    // Charge time unit
   localparam logic [SEL_W-1:0] CODE_ADC = 5'h1b;    // Converter
   localparam logic [SEL_W-1:0] CODE_CMP_LO = 5'h18; // Comparator one
   localparam logic [SEL_W-1:0] CODE_CMP_HI = 5'h1a; // Comparator three
   localparam logic [SEL_W-1:0] CODE_IC_LO = 5'h10;  // Capture one
   localparam logic [SEL_W-1:0] CODE_IC_HI = 5'h13;  // Capture four
   localparam logic [SEL_W-1:0] CODE_TMR_LO = 5'h0b; // Timer one
   localparam logic [SEL_W-1:0] CODE_TMR_HI = 5'h0f; // Timer five
   localparam logic [SEL_W-1:0] CODE_TRG = 5'h0a;    // Trigger generator
   localparam logic [SEL_W-1:0] CODE_OC_LO = 5'h01;  // Compare unit one
   localparam logic [SEL_W-1:0] CODE_OC_HI = 5'h04;  // Compare unit four
   localparam logic [SEL_W-1:0] CODE_NONE = 5'h00;   // Free running
   // -----------------------------------------------------------------
   // Source counts
   // -----------------------------------------------------------------
   localparam int N_CMP = 3;   // Analog comparators
   localparam int N_IC = 4;    // Capture units
   localparam int N_TMR = 5;   // Timers
   localparam int N_OC = 4;    // Compare units
   localparam int N_TRG = 4;   // Trigger generator outputs
endpackage
`default_nettype wire

// ### src/css_select.sv
// Sync/trigger source selector for one output compare unit
// Operation
// R1 - Five-bit select field picks sync source
// R2 - Code 11111 uses own secondary match
// R3 - Codes 11110/11101 take interrupt pins two/one
// R4 - 11100 charge unit, 11011 converter
// R5 - 11010..11000 take comparators three..one
// R6 - 10011..10000 take capture units four..one
// R7 - 01111..01011 take timers five..one
// R8 - Reset value 01100 selects timer two
// R9 - 01010 takes this unit's trigger generator
// R10 - 00100..00001 take compare units four..one
// R11 - 00000 means no source, free running
// R12 - Software never selects the unit itself
// R13 - Switched-off unit pulses its trigger output
// R14 - Software deselects source before disabling it
// R15 - Trigger generator output n feeds unit n+1
// R16 - Reserved codes select no source
`default_nettype none
module css_select
   import css_pkg::*;
#(
   parameter int UNIT_INDEX = 0 // Which compare unit this is, 0..3
)
(
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic sel_we_in,
   input wire logic [css_pkg::SEL_W-1:0] sel_data_in,
   input wire logic unit_enable_in,
   input wire logic self_match_in,
   input wire logic [1:0] ext_pin_in,
   input wire logic charge_time_unit_in,
   input wire logic converter_in,
   input wire logic [css_pkg::N_CMP-1:0] analog_comparator_in,
   input wire logic [css_pkg::N_IC-1:0] input_capture_in,
   input wire logic [css_pkg::N_TMR-1:0] timer_in,
   input wire logic [css_pkg::N_TRG-1:0] trigger_generator_output_in,
   input wire logic [css_pkg::N_OC-1:0] other_trigger_in,
   output logic [css_pkg::SEL_W-1:0] sync_source_select_out,
   output logic sync_event_out,
   output logic sync_enabled_out,
   output logic trigger_out
);
   import css_pkg::*;

   // -----------------------------------------------------------------
   // Reset release
   // -----------------------------------------------------------------
   logic rst_meta; // First release stage
   logic rst_sync_n; // Released reset copy

   // Two-stage release so all logic leaves reset on one edge
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rst_meta <= 1'b0;
         rst_sync_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   // -----------------------------------------------------------------
   // Select field
   // -----------------------------------------------------------------
   logic [SEL_W-1:0] sync_source_select; // Active code

   // Software write of the field; default is timer two
   always_ff @(posedge ref_clk_in or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         sync_source_select <= SEL_RESET; // R8
      end
      else if (sel_we_in)
      begin
         sync_source_select <= sel_data_in; // R1
      end
   end

   // -----------------------------------------------------------------
   // Source decode
   // -----------------------------------------------------------------
   // Offsets into each group; only meaningful inside the group's range
   wire [SEL_W-1:0] cmp_idx = sync_source_select - CODE_CMP_LO;
   wire [SEL_W-1:0] ic_idx = sync_source_select - CODE_IC_LO;
   wire [SEL_W-1:0] tmr_idx = sync_source_select - CODE_TMR_LO;
   wire [SEL_W-1:0] oc_idx = sync_source_select - CODE_OC_LO;
   wire in_cmp = sync_source_select >= CODE_CMP_LO && sync_source_select <= CODE_CMP_HI;
   wire in_ic = sync_source_select >= CODE_IC_LO && sync_source_select <= CODE_IC_HI;
   wire in_tmr = sync_source_select >= CODE_TMR_LO && sync_source_select <= CODE_TMR_HI;
   wire in_oc = sync_source_select >= CODE_OC_LO && sync_source_select <= CODE_OC_HI;
   // Own trigger generator line, fixed by unit index
   wire own_trg = trigger_generator_output_in[UNIT_INDEX]; // R15
   // Any decoded source; reserved codes and zero fall through to none
   wire [SEL_W-1:0] sel = sync_source_select;
   wire selected_valid = sel == CODE_SELF || sel == CODE_EXT2 || sel == CODE_EXT1
      || sel == CODE_CTU || sel == CODE_ADC || in_cmp || in_ic || in_tmr
      || sel == CODE_TRG || in_oc; // R11 R16

   // Multiplexed event, if-chain with no source as the fall-through
   logic next_event;
   always_comb
   begin
      next_event = 1'b0; // R11 R16
      if (sel == CODE_SELF)
      begin
         next_event = self_match_in; // R2
      end
      else if (sel == CODE_EXT2)
      begin
         next_event = ext_pin_in[1]; // R3
      end
      else if (sel == CODE_EXT1)
      begin
         next_event = ext_pin_in[0]; // R3
      end
      else if (sel == CODE_CTU)
      begin
         next_event = charge_time_unit_in; // R4
      end
      else if (sel == CODE_ADC)
      begin
         next_event = converter_in; // R4
      end
      else if (in_cmp)
      begin
         next_event = analog_comparator_in[cmp_idx[1:0]]; // R5
      end
      else if (in_ic)
      begin
         next_event = input_capture_in[ic_idx[1:0]]; // R6
      end
      else if (in_tmr)
      begin
         next_event = timer_in[tmr_idx[2:0]]; // R7
      end
      else if (sel == CODE_TRG)
      begin
         next_event = own_trg; // R9
      end
      else if (in_oc)
      begin
         // Self selection is a software fault; it is not blocked here
         next_event = other_trigger_in[oc_idx[1:0]]; // R10 R12
      end
   end

   // -----------------------------------------------------------------
   // Switch-off trigger pulse
   // -----------------------------------------------------------------
   logic disable_pulse; // One cycle on the falling edge of enable

   // Edge detector on the inverted enable; a unit going off pulses its
   // trigger, which a dependent unit will see unless it deselected us
   css_edge u_off_edge
   (
      .clk_in(ref_clk_in),
      .rst_n_in(rst_sync_n),
      .level_in(~unit_enable_in),
      .pulse_out(disable_pulse)
   );

   // -----------------------------------------------------------------
   // Output registers
   // -----------------------------------------------------------------
   // All outputs registered, one cycle after the source
   always_ff @(posedge ref_clk_in or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         sync_event_out <= 1'b0;
         sync_enabled_out <= 1'b0;
         trigger_out <= 1'b0;
         sync_source_select_out <= SEL_RESET;
      end
      else
      begin
         sync_event_out <= next_event;
         sync_enabled_out <= selected_valid;
         trigger_out <= disable_pulse; // R13
         sync_source_select_out <= sync_source_select;
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   a_reset_timer_two: assert property (@(posedge ref_clk_in) $rose(rst_sync_n)
      |-> sync_source_select == SEL_RESET) else $error("select not timer two"); // R8
   a_write_takes: assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n)
      sel_we_in |=> sync_source_select == $past(sel_data_in)) else $error("write lost"); // R1
   a_self_route: assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n)
      sel == CODE_SELF |=> sync_event_out == $past(self_match_in))
      else $error("self match not routed"); // R2
   a_ext_route: assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n)
      sel == CODE_EXT1 |=> sync_event_out == $past(ext_pin_in[0]))
      else $error("pin one not routed"); // R3
   a_adc_route: assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n)
      sel == CODE_ADC |=> sync_event_out == $past(converter_in))
      else $error("converter not routed"); // R4
   a_timer_route: assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n)
      in_tmr |=> sync_event_out == $past(timer_in[tmr_idx[2:0]]))
      else $error("timer not routed"); // R7
   a_trg_route: assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n)
      sel == CODE_TRG |=> sync_event_out == $past(own_trg))
      else $error("trigger generator not routed"); // R9
   a_none_quiet: assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n)
      !selected_valid |=> !sync_event_out && !sync_enabled_out)
      else $error("event with no source"); // R11
   a_off_pulse: assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n)
      $fell(unit_enable_in) |=> trigger_out ##1 !trigger_out)
      else $error("no switch-off pulse"); // R13

   // Second interrupt pin
   a_ext2_route: assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n) // R3
      sel == CODE_EXT2 |=> sync_event_out == $past(ext_pin_in[1]))
      else $error("pin two not routed");

   // Charge time unit
   a_ctu_route: assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n) // R4
      sel == CODE_CTU |=> sync_event_out == $past(charge_time_unit_in))
      else $error("charge unit not routed");

   // Lowest comparator code takes comparator one
   a_cmp_one: assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n) // R5
      sel == CODE_CMP_LO |=> sync_event_out == $past(analog_comparator_in[0]))
      else $error("comparator one not routed");

   // Highest comparator code takes comparator three
   a_cmp_three: assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n) // R5
      sel == CODE_CMP_HI |=> sync_event_out == $past(analog_comparator_in[2]))
      else $error("comparator three not routed");

   // Lowest capture code takes capture one
   a_ic_one: assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n) // R6
      sel == CODE_IC_LO |=> sync_event_out == $past(input_capture_in[0]))
      else $error("capture one not routed");

   // Highest capture code takes capture four
   a_ic_four: assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n) // R6
      sel == CODE_IC_HI |=> sync_event_out == $past(input_capture_in[3]))
      else $error("capture four not routed");

   // Lowest timer code takes timer one
   a_tmr_one: assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n) // R7
      sel == CODE_TMR_LO |=> sync_event_out == $past(timer_in[0]))
      else $error("timer one not routed");

   // Highest timer code takes timer five
   a_tmr_five: assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n) // R7
      sel == CODE_TMR_HI |=> sync_event_out == $past(timer_in[4]))
      else $error("timer five not routed");

   // Default code routes timer two
   a_tmr_default: assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n) // R8
      sel == SEL_RESET |=> sync_event_out == $past(timer_in[1]))
      else $error("default timer not routed");

   // Lowest compare unit code takes unit one
   a_oc_one: assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n) // R10
      sel == CODE_OC_LO |=> sync_event_out == $past(other_trigger_in[0]))
      else $error("unit one not routed");

   // Highest compare unit code takes unit four
   a_oc_four: assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n) // R10
      sel == CODE_OC_HI |=> sync_event_out == $past(other_trigger_in[3]))
      else $error("unit four not routed");

   // Zero code leaves the unit free running
   a_none_code: assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n) // R11
      sel == CODE_NONE |=> !sync_enabled_out)
      else $error("zero code shows a source");

   // Any decoded source raises the enabled flag
   a_valid_flag: assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n) // R16
      selected_valid |=> sync_enabled_out)
      else $error("valid source not flagged");

   // Visible copy trails the field by one cycle
   a_copy_follows: assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n) // R1
      1'b1 |=> sync_source_select_out == $past(sync_source_select))
      else $error("select copy stale");

   // Switch-off pulse lasts one cycle only
   a_pulse_single: assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n) // R13
      trigger_out |=> !trigger_out)
      else $error("trigger pulse too long");

   // Switch-off pulse only follows a falling enable
   a_pulse_cause: assert property (@(posedge ref_clk_in) disable iff (!rst_sync_n) // R13
      trigger_out |-> $past(unit_enable_in, 2) && !$past(unit_enable_in))
      else $error("trigger pulse without switch-off");
endmodule
`default_nettype wire

// ### tb/compare_sync_trigger_select_test.sv
// Self-checking bench for the compare sync source selector
`default_nettype none
module compare_sync_trigger_select_test;
   import css_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   `define CHK(nm, ex, gt) begin checks++; if ((ex) !== (gt)) begin failures++; $display("[ERR] %s expected %h seen %h", nm, ex, gt); end end
   // -----------------------------------------------------------------
   // Signals
   // -----------------------------------------------------------------
   localparam int UNIT = 1; // Bench instance is compare unit two
   logic clk, rst_n, we, en, chk;
   logic [4:0] data;
   logic [31:0] rnd, seed;
   logic [24:0] ev;
   logic [4:0] sel_o;
   logic ev_o, en_o, trg_o;
   logic [1:0] rs;
   logic [4:0] m_fld, x_sel;
   logic x_ev, x_en, x_trg, p_en;
   int failures = 0;
   int checks = 0;
   int cyc = 0;
   css_src_model u_css_src_model (.ref_clk_in(clk), .rnd_in(rnd), .ev_out(ev));
   css_select #(.UNIT_INDEX(UNIT)) u_css_select (.ref_clk_in(clk), .rst_n_in(rst_n),
      .sel_we_in(we), .sel_data_in(data), .unit_enable_in(en), .self_match_in(ev[0]),
      .ext_pin_in(ev[2:1]), .charge_time_unit_in(ev[3]), .converter_in(ev[4]),
      .analog_comparator_in(ev[7:5]), .input_capture_in(ev[11:8]), .timer_in(ev[16:12]),
      .trigger_generator_output_in(ev[20:17]), .other_trigger_in(ev[24:21]),
      .sync_source_select_out(sel_o), .sync_event_out(ev_o), .sync_enabled_out(en_o),
      .trigger_out(trg_o));
   // -----------------------------------------------------------------
   // Reference model
   // -----------------------------------------------------------------
   // Routed event for a code, or -1 where the code selects nothing
   function automatic int ref_src(input logic [4:0] c);
      int k;
      k = c;
      if (k == 31) return 0;
      if (k == 30) return 2;
      if (k == 29) return 1;
      if (k == 28) return 3;
      if (k == 27) return 4;
      if (k >= 24 && k <= 26) return 5 + k - 24;
      if (k >= 16 && k <= 19) return 8 + k - 16;
      if (k >= 11 && k <= 15) return 12 + k - 11;
      if (k == 10) return 17 + UNIT;
      if (k >= 1 && k <= 4) return 21 + k - 1;
      return -1;
   endfunction
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // Two-stage reset copy, as the design releases it
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n) rs <= 2'h0;
      else rs <= {rs[0], 1'b1};
   end
   // Expected outputs, one cycle behind field and inputs
   always @(posedge clk)
   begin
      if (!rs[1])
      begin
         m_fld <= 5'h0c;
         x_sel <= 5'h0c;
         {x_ev, x_en, x_trg, p_en} <= 4'h0;
      end
      else
      begin
         x_ev <= (ref_src(m_fld) < 0) ? 1'b0 : ev[ref_src(m_fld)];
         x_en <= ref_src(m_fld) >= 0;
         x_sel <= m_fld;
         x_trg <= p_en & !en;
         p_en <= en;
         if (we) m_fld <= data;
      end
   end
   // Results are settled by the falling edge
   always @(negedge clk)
   begin
      if (chk)
      begin
         `CHK("sync_event", x_ev, ev_o)
         `CHK("sync_enabled", x_en, en_o)
         `CHK("select_copy", x_sel, sel_o)
         `CHK("trigger", x_trg, trg_o)
      end
   end
   // -----------------------------------------------------------------
   // Stimulus
   // -----------------------------------------------------------------
   initial
   begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   task automatic step();
      @(posedge clk);
      seed = xs(seed);
      rnd <= seed;
      if (seed[31:29] == 3'h0) en <= !en;
   endtask
   task automatic after_reset();
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      `CHK("select_reset", 5'h0c, sel_o)
      chk <= 1'b1;
   endtask
   task automatic print_verdict();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Hang guard, well above the expected run length
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         failures++;
         print_verdict();
      end
   end
   initial
   begin
      {rst_n, we, en, chk} = 4'h0;
      data = 5'h00;
      rnd = '0;
      seed = 32'd68518;
      repeat (8) @(posedge clk);
      after_reset();
      $display("test reset_value done");
      // Back-to-back writes, own unit code kept out
      repeat (3)
      begin
         step();
         we <= 1'b1;
         data <= (seed[4:0] == 5'h02) ? 5'h1f : seed[4:0];
      end
      for (int i = 0; i < 32; i++)
      begin
         if (i == 2) continue;
         step();
         we <= 1'b1;
         data <= i[4:0];
         step();
         we <= 1'b0;
         repeat (18) step();
      end
      $display("test all_codes done");
      // Second reset in mid-run returns the default source
      en <= 1'b0;
      chk <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      after_reset();
      repeat (40) step();
      $display("test second_reset done");
      print_verdict();
   end
endmodule
`default_nettype wire

// ### tb/css_src_model.sv
// Far-side event sources that feed the selector
`default_nettype none
module css_src_model
(
   input wire logic ref_clk_in,
   input wire logic [31:0] rnd_in,
   output logic [24:0] ev_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // -----------------------------------------------------------------
   // Event strobes
   // -----------------------------------------------------------------
   // Fresh pattern every cycle, so a stale route shows up at once
   always @(posedge ref_clk_in)
   begin
      ev_out[20:0] <= rnd_in[20:0];
      // Other units' triggers; random bits like the rest, with no switch-off pulses modelled here
      ev_out[24:21] <= rnd_in[24:21];
   end
endmodule
`default_nettype wire
